/* hdl/eccs_pkg.sv */
// Package for the host-side controller of a cascadable error-correcting slice.
// Summary of operation
// - In 32-bit use the first slice feeds partial check bits to the second.
// - Wider than 32 bits, outside XOR logic combines slice outputs into the field.
// - One slice covers 16 data and 6 check bits; two cover 32 and 7.
// - For 48 bits drop slice 64A and use XNOR for syndrome bits one and two.
`default_nettype none
package eccs_pkg;
  // Word geometry of one slice.
  localparam int DATA_W    = 16;
  localparam int CHECK_W   = 7;
  localparam int PARTIAL_W = 6;
  localparam int CASC_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int IRQ_W     = 4;

  // Software register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_WCHECK = 8'h08;
  localparam logic [7:0] REG_CASC   = 8'h0c;
  localparam logic [7:0] REG_EXT    = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  localparam logic [7:0] REG_RSYN   = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_IRQ    = 8'h20;
  localparam logic [7:0] REG_MASK   = 8'h24;

  // Field positions.
  localparam int CTRL_START  = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CASC_SYN_IN = 8;
  localparam int EXT_XNOR    = 8;
  localparam int RSYN_SINGLE = 8;
  localparam int RSYN_ERR    = 9;
  localparam int RSYN_ZERO   = 10;
  localparam int RSYN_DOUBLE = 11;
  localparam int RSYN_ODD    = 12;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ERROR   = 1;
  localparam int IRQ_SINGLE  = 2;
  localparam int IRQ_MISMATCH = 3;

  // Reset values.
  localparam logic [IRQ_W-1:0]   MASK_RESET = 4'h0;
  localparam logic [CHECK_W-1:0] EXT_RESET  = 7'h00;

  // Timing: the slice is asynchronous, so the open window waits a settle time, then the hold waits SYNC_CYC cycles.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_NS     = 20;
  localparam int SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_CYC      = 3;
  localparam int CNT_W         = 4;

  // Operating modes: bit 1 clear means generate select high.
  typedef enum logic [1:0] {
    ECCS_MODE_WRITE   = 2'h0,
    ECCS_MODE_DIAG    = 2'h1,
    ECCS_MODE_CORRECT = 2'h2,
    ECCS_MODE_CHECK   = 2'h3
  } eccs_mode_t;

  typedef enum logic [2:0] {
    ECCS_IDLE,
    ECCS_OPEN,
    ECCS_HOLD,
    ECCS_CAPTURE
  } eccs_state_t;
endpackage
`default_nettype wire

/* hdl/eccs_syn_classify.sv */
// Syndrome classifier: zero, odd weight and double-error decode.
`default_nettype none
module eccs_syn_classify (
  input  wire logic [eccs_pkg::CHECK_W-1:0] syndrome,
  output logic                              syn_zero,
  output logic                              syn_odd,
  output logic                              syn_double
);
  // Weight parity decides the class; zero is its own case.
  always_comb begin
    syn_zero   = (syndrome == '0);
    syn_odd    = ^syndrome;
    syn_double = !syn_zero && !syn_odd;
  end
endmodule
`default_nettype wire

/* hdl/eccs_host.sv */
// Host controller that drives one error-correcting slice through its pins.
`default_nettype none
module eccs_host (
  input  wire logic                                clock,
  input  wire logic                                resetn,
  input  wire logic [eccs_pkg::ADDR_W-1:0]         addr,
  input  wire logic [31:0]                         wr_data,
  input  wire logic                                wr_strobe,
  input  wire logic                                rd_strobe,
  output logic      [31:0]                         rd_data,
  output logic                                     irq,
  output logic      [eccs_pkg::DATA_W-1:0]         slice_data_in,
  output logic      [eccs_pkg::CHECK_W-1:0]        slice_check_in,
  output logic                                     check_generate_select,
  output logic                                     correct_inhibit,
  output logic                                     output_latch_open,
  output logic      [eccs_pkg::PARTIAL_W-1:0]      partial_checkbit_in,
  output logic      [eccs_pkg::CASC_W-1:0]         cascade_syndrome_in,
  input  wire logic [eccs_pkg::DATA_W-1:0]         slice_data_out,
  input  wire logic [eccs_pkg::CHECK_W-1:0]        syndrome_checkbit_out,
  input  wire logic                                single_error_flag,
  input  wire logic                                error_flag
);
  localparam int SW = eccs_pkg::DATA_W + eccs_pkg::CHECK_W + 2;
  localparam logic [eccs_pkg::CNT_W-1:0] SETTLE_N = eccs_pkg::CNT_W'(eccs_pkg::SETTLE_CYC);
  localparam logic [eccs_pkg::CNT_W-1:0] SYNC_N   = eccs_pkg::CNT_W'(eccs_pkg::SYNC_CYC);

  typedef struct packed {
    eccs_pkg::eccs_state_t             state;
    logic [eccs_pkg::CNT_W-1:0]        cnt;
    logic [SW-1:0]                     sync1;
    logic [SW-1:0]                     sync2;
    logic [eccs_pkg::DATA_W-1:0]       wdata;
    logic [eccs_pkg::CHECK_W-1:0]      wcheck;
    logic [eccs_pkg::PARTIAL_W-1:0]    partial;
    logic [eccs_pkg::CASC_W-1:0]       casc;
    logic [eccs_pkg::CHECK_W-1:0]      ext;
    logic                              xnor12;
    eccs_pkg::eccs_mode_t              mode;
    logic                              make_check;
    logic                              inhibit;
    logic                              latch_open;
    logic [eccs_pkg::DATA_W-1:0]       rdata;
    logic [eccs_pkg::CHECK_W-1:0]      rsyn;
    logic [4:0]                        rflags;
    logic [eccs_pkg::IRQ_W-1:0]        irqs;
    logic [eccs_pkg::IRQ_W-1:0]        mask;
    logic [31:0]                       rd_data;
    logic                              irq;
  } eccs_host_t;

  eccs_host_t s_q;
  eccs_host_t s_d;

  logic [eccs_pkg::CHECK_W-1:0] full_syn;
  logic                         syn_zero;
  logic                         syn_odd;
  logic                         syn_double;

  // Read-side register decode, shared by the read path.
  function automatic logic [31:0] read_reg(input eccs_host_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      eccs_pkg::REG_WDATA:  r[eccs_pkg::DATA_W-1:0] = s.wdata;
      eccs_pkg::REG_WCHECK: r[eccs_pkg::CHECK_W-1:0] = s.wcheck;
      eccs_pkg::REG_CASC: begin
        r[eccs_pkg::PARTIAL_W-1:0] = s.partial;
        r[eccs_pkg::CASC_SYN_IN +: eccs_pkg::CASC_W] = s.casc;
      end
      eccs_pkg::REG_EXT: begin
        r[eccs_pkg::CHECK_W-1:0] = s.ext;
        r[eccs_pkg::EXT_XNOR] = s.xnor12;
      end
      eccs_pkg::REG_RDATA: r[eccs_pkg::DATA_W-1:0] = s.rdata;
      eccs_pkg::REG_RSYN: begin
        r[eccs_pkg::CHECK_W-1:0] = s.rsyn;
        r[eccs_pkg::RSYN_SINGLE +: 5] = s.rflags;
      end
      // Busy, and the mode of the last started operation for software to confirm.
      eccs_pkg::REG_STATUS: begin
        r[0]                         = (s.state != eccs_pkg::ECCS_IDLE);
        r[eccs_pkg::CTRL_MODE +: 2] = s.mode;
      end
      eccs_pkg::REG_IRQ:    r[eccs_pkg::IRQ_W-1:0] = s.irqs;
      eccs_pkg::REG_MASK:   r[eccs_pkg::IRQ_W-1:0] = s.mask;
      default:              r = 32'h0;
    endcase
    return r;
  endfunction

  // Slice outputs after the synchroniser: data, syndrome, single flag, error flag.
  // The external combine stands in for the XOR gates of a wide word; with ext left
  // at zero and no inversion it is the slice's own syndrome.
  always_comb begin
    full_syn = s_q.sync2[2 +: eccs_pkg::CHECK_W] ^ s_q.ext;
    if (s_q.xnor12) begin
      full_syn[2:1] = ~full_syn[2:1];
    end
  end

  eccs_syn_classify u_classify (
    .syndrome   (full_syn),
    .syn_zero   (syn_zero),
    .syn_odd    (syn_odd),
    .syn_double (syn_double)
  );

  // Next-state logic: register writes, the pin sequence and the interrupt bits.
  always_comb begin
    logic [eccs_pkg::IRQ_W-1:0] set;
    logic [eccs_pkg::IRQ_W-1:0] clr;
    logic                       mism;
    set   = '0;
    clr   = '0;
    mism  = 1'b0;
    s_d   = s_q;
    s_d.sync1 = {slice_data_out, syndrome_checkbit_out, single_error_flag, error_flag};
    s_d.sync2 = s_q.sync1;
    s_d.rd_data = rd_strobe ? read_reg(s_q, addr) : 32'h0;
    if (wr_strobe) begin
      case (addr)
        eccs_pkg::REG_WDATA:  s_d.wdata = wr_data[eccs_pkg::DATA_W-1:0];
        eccs_pkg::REG_WCHECK: s_d.wcheck = wr_data[eccs_pkg::CHECK_W-1:0];
        eccs_pkg::REG_CASC: begin
          s_d.partial = wr_data[eccs_pkg::PARTIAL_W-1:0];
          s_d.casc    = wr_data[eccs_pkg::CASC_SYN_IN +: eccs_pkg::CASC_W];
        end
        eccs_pkg::REG_EXT: begin
          s_d.ext    = wr_data[eccs_pkg::CHECK_W-1:0];
          s_d.xnor12 = wr_data[eccs_pkg::EXT_XNOR];
        end
        eccs_pkg::REG_IRQ:  clr = wr_data[eccs_pkg::IRQ_W-1:0];
        eccs_pkg::REG_MASK: s_d.mask = wr_data[eccs_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    case (s_q.state)
      eccs_pkg::ECCS_IDLE: begin
        s_d.latch_open = 1'b0;
        if (wr_strobe && addr == eccs_pkg::REG_CTRL && wr_data[eccs_pkg::CTRL_START]) begin
          s_d.mode       = eccs_pkg::eccs_mode_t'(wr_data[eccs_pkg::CTRL_MODE +: 2]);
          s_d.make_check = !wr_data[eccs_pkg::CTRL_MODE + 1];
          s_d.inhibit    = wr_data[eccs_pkg::CTRL_MODE];
          s_d.latch_open = 1'b1;
          s_d.cnt     = SETTLE_N;
          s_d.state   = eccs_pkg::ECCS_OPEN;
        end
      end
      eccs_pkg::ECCS_OPEN: begin
        // Latches stay open until the asynchronous slice paths have settled.
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.latch_open = 1'b0;
          s_d.cnt   = SYNC_N;
          s_d.state = eccs_pkg::ECCS_HOLD;
        end
      end
      eccs_pkg::ECCS_HOLD: begin
        // Wait out the synchroniser so the sampled values are the held ones.
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.state = eccs_pkg::ECCS_CAPTURE;
        end
      end
      eccs_pkg::ECCS_CAPTURE: begin
        s_d.rdata  = s_q.sync2[SW-1 -: eccs_pkg::DATA_W];
        s_d.rsyn   = full_syn;
        s_d.rflags = {syn_odd, syn_double, syn_zero, s_q.sync2[0], s_q.sync2[1]};
        if (s_q.make_check) begin
          mism = s_q.sync2[1] || s_q.sync2[0];
        end else begin
          mism = (s_q.sync2[0] == syn_zero) || (s_q.sync2[1] && !s_q.sync2[0]);
        end
        set[eccs_pkg::IRQ_DONE]     = 1'b1;
        set[eccs_pkg::IRQ_ERROR]    = s_q.sync2[0] && !s_q.make_check;
        set[eccs_pkg::IRQ_SINGLE]   = s_q.sync2[1] && !s_q.make_check;
        set[eccs_pkg::IRQ_MISMATCH] = mism;
        s_d.state = eccs_pkg::ECCS_IDLE;
      end
      default: s_d.state = eccs_pkg::ECCS_IDLE;
    endcase
    // Setting wins over a clear in the same cycle.
    s_d.irqs = (s_q.irqs & ~clr) | set;
    s_d.irq  = |(s_d.irqs & s_d.mask);
  end

  // State register; reset puts the slice in write mode with latches closed.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.state <= eccs_pkg::ECCS_IDLE;
      s_q.mode  <= eccs_pkg::ECCS_MODE_WRITE;
      s_q.make_check <= 1'b1;
      s_q.ext   <= eccs_pkg::EXT_RESET;
      s_q.mask  <= eccs_pkg::MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register.
  assign rd_data               = s_q.rd_data;
  assign irq                   = s_q.irq;
  assign slice_data_in         = s_q.wdata;
  assign slice_check_in        = s_q.wcheck;
  assign check_generate_select = s_q.make_check;
  assign correct_inhibit       = s_q.inhibit;
  assign output_latch_open     = s_q.latch_open;
  assign partial_checkbit_in   = s_q.partial;
  assign cascade_syndrome_in   = s_q.casc;
endmodule
`default_nettype wire

/* verification/eccs_slice_model.sv */
// Behavioural model of one error-correcting slice wired as position 16.
`default_nettype none
module eccs_slice_model #(
  parameter int RESP_NS = 3
) (
  input  wire logic [15:0] data_in,
  input  wire logic [6:0]  check_in,
  input  wire logic        make_check,
  input  wire logic        inhibit,
  input  wire logic        latch_open,
  input  wire logic        fault,
  output logic      [15:0] data_out,
  output logic      [6:0]  syn_out,
  output logic             single_err,
  output logic             err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  s;
  logic [15:0] fix;
  logic [15:0] dq;
  logic        sq;
  logic        eq;
  //////////////////////////////////////////////////////////////////////
  // Each mask lists the data bits that one parity term covers.
  function automatic logic [5:0] par(input logic [15:0] d);
    par = {^(d & 16'hff00), ^(d & 16'hf0f0), ^(d & 16'h8cce),
           ^(d & 16'h433d), ^(d & 16'h2aab), ^(d & 16'h1557)};
  endfunction
  // Terms one and two are inverted so an all-zero word still shows ones.
  always_comb begin
    s   = par(data_in) ^ 6'h06 ^ check_in[5:0];
    fix = 16'h0;
    for (int i = 0; i < 16; i++) begin
      if (s == par(16'h1 << i)) fix[i] = 1'b1;
    end
  end
  // A closed enable keeps the last answer, which is what the host captures.
  always_latch begin
    if (latch_open) begin
      dq = (!make_check && !inhibit) ? data_in ^ fix : data_in;
      sq = !make_check && (|fix || $onehot(s));
      eq = make_check ? fault : |s;
    end
  end
  // The delay stands for the slow glass that the host must wait out.
  assign #RESP_NS syn_out = make_check ? (inhibit ? 7'h06
                                                  : {1'b0, par(data_in) ^ 6'h06})
                                       : {1'b0, s};
  assign #RESP_NS {data_out, single_err, err} = {dq, sq, eq};
endmodule
`default_nettype wire

/* verification/eccs_host_sva.sv */
// Assertions on the host controller pins.
`default_nettype none
module eccs_host_sva (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_strobe,
  input wire logic        rd_strobe,
  input wire logic [31:0] rd_data,
  input wire logic [15:0] slice_data_in,
  input wire logic        check_generate_select,
  input wire logic        correct_inhibit,
  input wire logic        output_latch_open,
  input wire logic [5:0]  partial_checkbit_in,
  input wire logic [7:0]  cascade_syndrome_in
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////
  // Read data stand one cycle only; unmapped places read as zero.
  a_read_slot: assert property (!rd_strobe |=> rd_data == 32'h0)
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (rd_strobe && addr == 8'h40 |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  // The open window lasts the settle time, then the hold time follows.
  a_open_width: assert property (
    $rose(output_latch_open) |-> output_latch_open [*4] ##1 !output_latch_open)
    else $error("latch window length wrong");
  a_hold_gap: assert property ($fell(output_latch_open) |-> !output_latch_open [*4])
    else $error("latch reopened too soon");
  a_mode_steady: assert property (
    output_latch_open && $past(output_latch_open) |->
    $stable(check_generate_select) && $stable(correct_inhibit))
    else $error("mode moved while latch open");
  // Only a start write opens the latch, with the written mode.
  a_open_cause: assert property (
    $rose(output_latch_open) |-> $past(wr_strobe && addr == eccs_pkg::REG_CTRL && wr_data[0]))
    else $error("latch opened without start");
  a_mode_map: assert property ($rose(output_latch_open) |->
    check_generate_select == !$past(wr_data[2]) && correct_inhibit == $past(wr_data[1]))
    else $error("mode pins wrong");
  // Slice inputs follow their registers.
  a_data_follow: assert property (
    wr_strobe && addr == eccs_pkg::REG_WDATA |=> slice_data_in == $past(wr_data[15:0]))
    else $error("data pins do not follow");
  a_casc_follow: assert property (wr_strobe && addr == eccs_pkg::REG_CASC |=>
    {cascade_syndrome_in, partial_checkbit_in} == $past({wr_data[15:8], wr_data[5:0]}))
    else $error("cascade pins do not follow");
  c_correct: cover property ($rose(output_latch_open) && !check_generate_select);
  c_diag: cover property ($rose(output_latch_open) && correct_inhibit && check_generate_select);
  c_read: cover property (rd_strobe && addr == eccs_pkg::REG_IRQ);
endmodule
bind eccs_host eccs_host_sva u_sva (.*);
`default_nettype wire

/* verification/eccs_host_tb.sv */
// Self-checking bench for the slice host controller.
`default_nettype none
module eccs_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, resetn = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0, fault = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic        irq, make_check, inh, latch_open, single_err, err;
  logic [15:0] din, dout;
  logic [6:0]  cin, syn_out;
  int          failures = 0, n_checks = 0, cycles = 0;
  localparam logic [31:0] FM = 32'hffffffff;
  localparam logic [31:0] WM = 32'h7f | (32'h1 << eccs_pkg::RSYN_SINGLE)
                               | (32'h1 << eccs_pkg::RSYN_ERR);
  //////////////////////////////////////////////////////////////////////
  eccs_host u_dut (.clock(clock), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .irq(irq),
    .slice_data_in(din), .slice_check_in(cin), .check_generate_select(make_check),
    .correct_inhibit(inh), .output_latch_open(latch_open), .partial_checkbit_in(),
    .cascade_syndrome_in(), .slice_data_out(dout), .syndrome_checkbit_out(syn_out),
    .single_error_flag(single_err), .error_flag(err));
  eccs_slice_model u_model (.data_in(din), .check_in(cin), .make_check(make_check),
    .inhibit(inh), .latch_open(latch_open), .fault(fault), .data_out(dout),
    .syn_out(syn_out), .single_err(single_err), .err(err));
  // Clock and a ceiling that cuts a hung run short.
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      summarize();
    end
  end
  task automatic summarize();
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus cycles: strobes rise after an edge and fall after the taking edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a; wr_data <= d; wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    @(posedge clock);
    addr <= a; rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1 if (n != "") chk(n, e & m, rd_data & m);
  endtask
  function automatic logic [31:0] rs(input logic [6:0] s, input logic sf, input logic ef);
    rs = {25'h0, s} | (32'(sf) << eccs_pkg::RSYN_SINGLE) | (32'(ef) << eccs_pkg::RSYN_ERR)
       | (32'(s == 7'h0) << eccs_pkg::RSYN_ZERO) | (32'(^s) << eccs_pkg::RSYN_ODD)
       | (32'(s != 7'h0 && !(^s)) << eccs_pkg::RSYN_DOUBLE);
  endfunction
  // One slice operation, polled to completion, then both results read.
  task automatic op(input logic [1:0] md, input logic [15:0] d, input logic [6:0] c,
                    input logic [15:0] ed, input logic [31:0] es, input logic [31:0] m);
    wr(eccs_pkg::REG_WDATA, {16'h0, d});
    wr(eccs_pkg::REG_WCHECK, {25'h0, c});
    wr(eccs_pkg::REG_CTRL, {29'h0, md, 1'b1});
    // A sequence that never ends shows up as a busy bit that outlives the poll.
    for (int i = 0; i < 20 && (i == 0 || rd_data[0] !== 1'b0); i++) begin
      rdc("", eccs_pkg::REG_STATUS, 32'h0, 32'h0);
    end
    chk("busy", 32'h0, 32'(rd_data[0]));
    rdc("data_out", eccs_pkg::REG_RDATA, {16'h0, ed}, FM);
    rdc("syndrome", eccs_pkg::REG_RSYN, es, m);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rdc("mask", eccs_pkg::REG_MASK, 32'h0, FM);
    rdc("unmapped", 8'h40, 32'h0, FM);
    wr(eccs_pkg::REG_MASK, 32'hf);
    wr(eccs_pkg::REG_CASC, 32'h5a3c);
    rdc("casc", eccs_pkg::REG_CASC, 32'h5a3c, FM);
    op(2'h0, 16'h0001, 7'h00, 16'h0001, 32'h1, WM);
    op(2'h1, 16'h1234, 7'h00, 16'h1234, 32'h6, WM);
    op(2'h2, 16'h8000, 7'h06, 16'h0000, rs(7'h38, 1'b1, 1'b1), FM);
    chk("irq", 32'h1, 32'(irq));
    rdc("irq_bits", eccs_pkg::REG_IRQ, 32'h7, 32'hf);
    wr(eccs_pkg::REG_IRQ, 32'hf);
    rdc("irq_clear", eccs_pkg::REG_IRQ, 32'h0, 32'hf);
    chk("irq_low", 32'h0, 32'(irq));
    op(2'h3, 16'h8000, 7'h06, 16'h8000, rs(7'h38, 1'b1, 1'b1), FM);
    rdc("mode", eccs_pkg::REG_STATUS, 32'h6, FM);
    op(2'h2, 16'h0000, 7'h07, 16'h0000, rs(7'h01, 1'b1, 1'b1), FM);
    op(2'h2, 16'h0003, 7'h06, 16'h0003, rs(7'h0c, 1'b0, 1'b1), FM);
    op(2'h2, 16'h0000, 7'h06, 16'h0000, rs(7'h00, 1'b0, 1'b0), FM);
    wr(eccs_pkg::REG_EXT, 32'h101);
    rdc("ext", eccs_pkg::REG_EXT, 32'h101, FM);
    op(2'h2, 16'h0000, 7'h06, 16'h0000, rs(7'h07, 1'b0, 1'b0), FM);
    wr(eccs_pkg::REG_EXT, 32'h0);
    wr(eccs_pkg::REG_MASK, 32'h0);
    op(2'h2, 16'h8000, 7'h06, 16'h0000, rs(7'h38, 1'b1, 1'b1), FM);
    chk("irq_masked", 32'h0, 32'(irq));
    wr(eccs_pkg::REG_IRQ, 32'hf);
    wr(eccs_pkg::REG_MASK, 32'hf);
    fault <= 1'b1;
    op(2'h0, 16'h0000, 7'h00, 16'h0000, 32'h6, 32'h7f);
    rdc("mismatch", eccs_pkg::REG_IRQ, 32'h8, 32'h8);
    fault <= 1'b0;
    summarize();
  end
endmodule
`default_nettype wire
